// >>> sceg_flash_model.sv
// Flash side model answering the guard's password word reads
`timescale 1ns/100ps
`default_nettype none
`include "sceg_regs.svh"
module sceg_flash_model (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic                    req,
    input  wire logic [`SCEG_ADDR_W-1:0] addr,
    input  wire logic [`SCEG_KEY_W-1:0]  pw_lo,
    input  wire logic [1:0]              slow,
    output var  logic                    ack,
    output var  logic [`SCEG_WORD_W-1:0] data,
    output var  logic                    order_err
);
    logic [2:0] n_q = 3'h0;
    logic [1:0] wait_q = 2'h0;
    initial begin
        ack = 1'b0;
        data = 16'h0000;
        order_err = 1'b0;
    end
    // Data flips when idle so a stale word never passes for a fresh one
    always @(negedge clk) begin
        data <= ~data;
        ack <= 1'b0;
        if (srst) begin
            n_q <= 3'h0;
            wait_q <= 2'h0;
        end else if (req && !ack && wait_q == slow) begin
            ack <= 1'b1;
            wait_q <= 2'h0;
            n_q <= n_q + 3'h1;
            data <= (n_q < 3'h4) ? pw_lo[n_q*16 +: 16] : 16'hA5A5;
            if (addr !== `SCEG_PW_BASE + 22'(n_q)) order_err <= 1'b1;
        end else if (req && !ack) begin
            wait_q <= wait_q + 2'h1;
        end
    end
endmodule : sceg_flash_model
`default_nettype wire

// >>> sceg_guard.sv
// Code security gate and emulation security trip for secure memories
//
// Summary of operation
// - Block reads of flash, OTP and L0-L3 blocks not made from secure code, both L0-L3 mappings.
// - Emulator attached plus fetch or access to secure memory trips, cutting emulator.
// - Key low 64 bits matching password low 64 bits unlock emulation; reads stay blocked.
// - Password low 64 bits all ones unlocks emulation without a key match.
// - Wait-in-reset mode holds the CPU until the emulator takes control.
`timescale 1ns/100ps
`default_nettype none
`include "sceg_regs.svh"
module sceg_guard
    import sceg_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic                    emu_attach_pin,
    input  wire logic                    emu_wait_rst_pin,
    input  wire logic                    emu_ctrl_pin,
    input  wire logic                    acc_valid,
    input  wire logic [`SCEG_ADDR_W-1:0] acc_addr,
    input  wire logic                    acc_read,
    input  wire logic                    acc_from_secure,
    input  wire logic                    key_wr,
    input  wire logic [`SCEG_KEY_W-1:0]  key_lo,
    output var  logic                    flash_rd_req_q,
    output var  logic [`SCEG_ADDR_W-1:0] flash_rd_addr_q,
    input  wire logic                    flash_rd_ack,
    input  wire logic [`SCEG_WORD_W-1:0] flash_rd_data,
    output var  logic                    cpu_hold_q,
    output var  logic                    rd_allow_q,
    output var  logic                    rd_block_q,
    output var  logic                    emu_cut_q,
    output var  logic                    emu_unlock_q
);
    sceg_pw_if pw ();

    sceg_pwd_fetch u_fetch (
        .clk             (clk),
        .srst            (srst),
        .flash_rd_req_q  (flash_rd_req_q),
        .flash_rd_addr_q (flash_rd_addr_q),
        .flash_rd_ack    (flash_rd_ack),
        .flash_rd_data   (flash_rd_data),
        .pw              (pw.loader)
    );

    function automatic sceg_region_type region_of(input logic [`SCEG_ADDR_W-1:0] a);
        sceg_region_type r;
        r = SCEG_RG_NONE;
        if (a >= `SCEG_FLASH_LO && a <= `SCEG_FLASH_HI) begin
            r = SCEG_RG_FLASH;
        end else if (a >= `SCEG_OTP_LO && a <= `SCEG_OTP_HI) begin
            r = SCEG_RG_OTP;
        end else if (a >= `SCEG_LRAM_LO && a <= `SCEG_LRAM_HI) begin
            r = SCEG_RG_LRAM;
        end else if (a >= `SCEG_LMIR_LO && a <= `SCEG_LMIR_HI) begin
            r = SCEG_RG_LRAM;
        end
        return r;
    endfunction : region_of

    // Pins from the emulator side: two flops each before any use
    logic [2:0] pin_raw_w;
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    assign pin_raw_w = {emu_ctrl_pin, emu_wait_rst_pin, emu_attach_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (srst) begin
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= pin_raw_w[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    logic emu_on_w;
    logic wait_mode_w;
    logic emu_ctrl_w;
    logic secure_w;
    logic trip_w;
    logic key_match_w;
    logic unlock_now_w;
    logic block_w;
    logic hold_w;
    logic cpu_hold_d;
    logic rd_allow_d;
    logic rd_block_d;
    logic emu_cut_d;
    logic emu_unlock_d;
    sceg_region_type region_w;

    assign emu_on_w     = sync_q[0];
    assign wait_mode_w  = sync_q[1];
    assign emu_ctrl_w   = sync_q[2];
    assign region_w     = region_of(acc_addr);
    assign secure_w     = (region_w != SCEG_RG_NONE);
    assign block_w      = acc_valid && acc_read && secure_w && !acc_from_secure;
    // Accesses are not taken while the CPU is held, so nothing trips early
    assign trip_w       = acc_valid && secure_w && emu_on_w && !emu_unlock_q && !cpu_hold_q;
    assign key_match_w  = key_wr && (key_lo == pw.pw_lo);
    assign unlock_now_w = pw.ready && (pw.blank || key_match_w);
    // Hold also covers the password fetch, so no decision runs on a stale key
    assign hold_w       = !pw.ready || (wait_mode_w && !emu_ctrl_w);

    // Next values; cut and unlock are sticky, only srst clears them
    assign cpu_hold_d   = hold_w;
    assign rd_allow_d   = acc_valid && acc_read && !block_w;
    assign rd_block_d   = block_w;
    assign emu_cut_d    = emu_cut_q || trip_w;
    assign emu_unlock_d = emu_unlock_q || unlock_now_w;

    always_ff @(posedge clk) begin
        if (srst) begin
            cpu_hold_q <= 1'b1;
        end else begin
            cpu_hold_q <= cpu_hold_d;
        end
    end

    // Read verdicts are one-cycle pulses, one per read access
    always_ff @(posedge clk) begin
        if (srst) begin
            rd_allow_q <= 1'b0;
            rd_block_q <= 1'b0;
        end else begin
            rd_allow_q <= rd_allow_d;
            rd_block_q <= rd_block_d;
        end
    end

    // No clear path on purpose: a cut link must not be revived by software
    always_ff @(posedge clk) begin
        if (srst) begin
            emu_cut_q    <= 1'b0;
            emu_unlock_q <= 1'b0;
        end else begin
            emu_cut_q    <= emu_cut_d;
            emu_unlock_q <= emu_unlock_d;
        end
    end

    // One clock for all checks; reset silences them
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    trip_cuts_emu_a: assert property (trip_w |=> emu_cut_q)
        else $error("secure access with emulator did not cut the link");
    cut_stays_a: assert property (emu_cut_q |=> emu_cut_q ##1 emu_cut_q)
        else $error("emulator cut released before reset");
    key_unlock_a: assert property (pw.ready && key_match_w |=> emu_unlock_q)
        else $error("matching key did not unlock emulation");
    read_block_a: assert property (block_w |=> rd_block_q && !rd_allow_q)
        else $error("secure read was not blocked");
    unlocked_read_a: assert property (emu_unlock_q && block_w |=> rd_block_q)
        else $error("unlock let a secure read through");
    blank_unlock_a: assert property (pw.ready && pw.blank && !emu_unlock_q |=> emu_unlock_q)
        else $error("blank password did not unlock emulation");
    unlock_keeps_a: assert property (emu_unlock_q |=> emu_unlock_q)
        else $error("emulation unlock dropped before reset");
    reset_relock_a: assert property ($past(srst) |-> !emu_unlock_q && cpu_hold_q && !emu_cut_q)
        else $error("state not cleared by reset");
    wait_hold_a: assert property (wait_mode_w && !emu_ctrl_w |=> cpu_hold_q)
        else $error("wait-in-reset did not hold the cpu");
    held_no_trip_a: assert property (cpu_hold_q && !emu_cut_q |=> !emu_cut_q)
        else $error("guard tripped while cpu held");

    // Read verdicts for every other kind of read
    own_read_a: assert property (
        acc_valid && acc_read && secure_w && acc_from_secure |=> rd_allow_q && !rd_block_q)
        else $error("read from secure code was refused");
    open_read_a: assert property (
        acc_valid && acc_read && !secure_w |=> rd_allow_q && !rd_block_q)
        else $error("read of open memory was refused");
    no_verdict_a: assert property (
        !(acc_valid && acc_read) |=> !rd_allow_q && !rd_block_q)
        else $error("read verdict without a read");
    otp_block_a: assert property (
        acc_valid && acc_read && !acc_from_secure && region_w == SCEG_RG_OTP |=> rd_block_q)
        else $error("one-time memory read was not blocked");
    ram_block_a: assert property (
        acc_valid && acc_read && !acc_from_secure && region_w == SCEG_RG_LRAM |=> rd_block_q)
        else $error("secure ram read was not blocked");
    // Cut and unlock move only on their own causes
    detached_no_cut_a: assert property (
        !emu_on_w && !emu_cut_q |=> !emu_cut_q)
        else $error("link cut with no emulator attached");
    open_no_cut_a: assert property (
        !(acc_valid && secure_w) && !emu_cut_q |=> !emu_cut_q)
        else $error("link cut without a secure access");
    unlock_no_cut_a: assert property (
        emu_unlock_q && !emu_cut_q |=> !emu_cut_q)
        else $error("link cut while emulation unlocked");
    bad_key_a: assert property (
        pw.ready && !pw.blank && !key_match_w && !emu_unlock_q |=> !emu_unlock_q)
        else $error("unlock without a matching key");
    early_key_a: assert property (
        !pw.ready && !emu_unlock_q |=> !emu_unlock_q)
        else $error("unlock before the password was fetched");
    // Hold follows the password fetch and the wait mode
    fetch_hold_a: assert property (
        !pw.ready |=> cpu_hold_q)
        else $error("cpu ran during the password fetch");
    hold_release_a: assert property (
        pw.ready && !(wait_mode_w && !emu_ctrl_w) |=> !cpu_hold_q)
        else $error("cpu still held after fetch and emulator ready");

    cov_trip_c:   cover property (!emu_cut_q ##1 emu_cut_q);
    cov_key_c:    cover property (pw.ready && !pw.blank && key_match_w ##1 emu_unlock_q);
    cov_blank_c:  cover property (pw.ready && pw.blank ##1 emu_unlock_q);
    cov_block_c:  cover property (emu_unlock_q && rd_block_q);
    cov_held_c:   cover property (cpu_hold_q && acc_valid && secure_w && emu_on_w);
endmodule : sceg_guard
`default_nettype wire

// >>> sceg_pkg.sv
// Types shared by the guard and its password fetcher
package sceg_pkg;
    typedef enum logic [1:0] {
        SCEG_LD_REQ,
        SCEG_LD_WAIT,
        SCEG_LD_DONE
    } sceg_ld_state_type;

    typedef enum logic [1:0] {
        SCEG_RG_NONE,
        SCEG_RG_FLASH,
        SCEG_RG_OTP,
        SCEG_RG_LRAM
    } sceg_region_type;
endpackage : sceg_pkg

// >>> sceg_pw_if.sv
// Stored password handed from the fetcher to the guard
`timescale 1ns/100ps
`default_nettype none
`include "sceg_regs.svh"
interface sceg_pw_if;
    logic [`SCEG_KEY_W-1:0] pw_lo;
    logic                   ready;
    logic                   blank;
    modport loader (output pw_lo, output ready, output blank);
    modport guard  (input pw_lo, input ready, input blank);
endinterface : sceg_pw_if
`default_nettype wire

// >>> sceg_pwd_fetch.sv
// Reads the eight password words from flash after every reset
`timescale 1ns/100ps
`default_nettype none
`include "sceg_regs.svh"
module sceg_pwd_fetch
    import sceg_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      srst,
    output var  logic                      flash_rd_req_q,
    output var  logic [`SCEG_ADDR_W-1:0]   flash_rd_addr_q,
    input  wire logic                      flash_rd_ack,
    input  wire logic [`SCEG_WORD_W-1:0]   flash_rd_data,
    sceg_pw_if.loader                      pw
);
    sceg_ld_state_type              state_q;
    logic [3:0]                     idx_q;
    logic [`SCEG_KEY_W-1:0]         pw_q;
    logic                           last_w;
    logic                           keep_w;

    assign last_w   = (idx_q == `SCEG_PW_WORDS - 4'h1);
    // Only the low four words take part in the emulation key compare
    assign keep_w   = (idx_q < `SCEG_PW_LO_WORDS);
    assign pw.pw_lo = pw_q;
    assign pw.ready = (state_q == SCEG_LD_DONE);
    assign pw.blank = (pw_q == `SCEG_PW_BLANK);

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q         <= SCEG_LD_REQ;
            idx_q           <= 4'h0;
            pw_q            <= '0;
            flash_rd_req_q  <= 1'b0;
            flash_rd_addr_q <= `SCEG_PW_BASE;
        end else begin
            case (state_q)
                SCEG_LD_REQ: begin
                    flash_rd_req_q  <= 1'b1;
                    flash_rd_addr_q <= `SCEG_PW_BASE + {18'h0_0000, idx_q};
                    state_q         <= SCEG_LD_WAIT;
                end
                SCEG_LD_WAIT: begin
                    if (flash_rd_ack) begin
                        flash_rd_req_q <= 1'b0;
                        if (keep_w) begin
                            pw_q[idx_q[1:0]*16 +: 16] <= flash_rd_data;
                        end
                        idx_q   <= idx_q + 4'h1;
                        state_q <= last_w ? SCEG_LD_DONE : SCEG_LD_REQ;
                    end
                end
                default: begin
                    state_q <= SCEG_LD_DONE;
                end
            endcase
        end
    end

    pw_addr_range_a: assert property (@(posedge clk) disable iff (srst)
        flash_rd_req_q |-> (flash_rd_addr_q >= `SCEG_PW_BASE) && (flash_rd_addr_q <= `SCEG_PW_LAST))
        else $error("password read outside the password words");
endmodule : sceg_pwd_fetch
`default_nettype wire

// >>> sceg_regs.svh
// Address map, password location and sizes for the secure memory emulation guard
`ifndef SCEG_REGS_SVH
`define SCEG_REGS_SVH

`define SCEG_ADDR_W      22
`define SCEG_KEY_W       64
`define SCEG_WORD_W      16
`define SCEG_PW_BASE     22'h33_FFF8
`define SCEG_PW_LAST     22'h33_FFFF
`define SCEG_PW_WORDS    4'h8
`define SCEG_PW_LO_WORDS 4'h4
`define SCEG_PW_BLANK    64'hFFFF_FFFF_FFFF_FFFF
`define SCEG_FLASH_LO    22'h30_0000
`define SCEG_FLASH_HI    22'h33_FFFF
`define SCEG_OTP_LO      22'h38_0000
`define SCEG_OTP_HI      22'h38_07FF
`define SCEG_LRAM_LO     22'h00_8000
`define SCEG_LRAM_HI     22'h00_BFFF
`define SCEG_LMIR_LO     22'h3F_8000
`define SCEG_LMIR_HI     22'h3F_BFFF

`endif

// >>> tb_sceg_guard.sv
// Self-checking bench for the secure memory emulation guard
`timescale 1ns/100ps
`default_nettype none
`include "sceg_regs.svh"
module tb_sceg_guard;
    logic        clk = 1'b0, srst = 1'b1, emu_att = 1'b0, emu_wrm = 1'b0, emu_ctl = 1'b0;
    logic        acc_valid = 1'b0, acc_read = 1'b0, acc_sec = 1'b0, key_wr = 1'b0;
    logic [21:0] acc_addr = 22'h00_0000;
    logic [63:0] key_lo = 64'h0, pw_lo = 64'h1234_5678_9ABC_DEF0;
    logic [1:0]  slow = 2'h2;
    logic        req, ack, hold, allow, block, cut, unlock, order_err;
    logic [21:0] req_addr;
    logic [15:0] data;
    int          n_errors = 0, total_checks = 0;
    logic [21:0] prot [5] = '{22'h30_0000, 22'h33_FFFF, 22'h38_0000, 22'h00_8000, 22'h3F_BFFF};

    always #2.5 clk = ~clk;

    sceg_guard i_sceg_guard (.clk(clk), .srst(srst), .emu_attach_pin(emu_att), .emu_wait_rst_pin(emu_wrm),
        .emu_ctrl_pin(emu_ctl), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_read(acc_read),
        .acc_from_secure(acc_sec), .key_wr(key_wr), .key_lo(key_lo), .flash_rd_req_q(req),
        .flash_rd_addr_q(req_addr), .flash_rd_ack(ack), .flash_rd_data(data), .cpu_hold_q(hold),
        .rd_allow_q(allow), .rd_block_q(block), .emu_cut_q(cut), .emu_unlock_q(unlock));
    sceg_flash_model i_sceg_flash_model (.clk(clk), .srst(srst), .req(req), .addr(req_addr),
        .pw_lo(pw_lo), .slow(slow), .ack(ack), .data(data), .order_err(order_err));

    task automatic close_out;
        if (n_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic do_reset;
        int i;
        @(negedge clk) srst = 1'b1;
        repeat (4) @(negedge clk);
        chk({hold, allow, block, cut, unlock, req}, 64'h20);
        srst = 1'b0;
        for (i = 0; i < 300 && hold !== 1'b0; i++) @(negedge clk);
    endtask : do_reset

    task automatic acc(input logic [21:0] a, input logic rd, input logic sec, input logic [1:0] exp);
        @(negedge clk);
        acc_valid = 1'b1;
        acc_addr = a;
        acc_read = rd;
        acc_sec = sec;
        @(negedge clk) acc_valid = 1'b0;
        chk({allow, block}, exp);
    endtask : acc

    task automatic key(input logic [63:0] k, input logic exp);
        @(negedge clk);
        key_wr = 1'b1;
        key_lo = k;
        @(negedge clk) key_wr = 1'b0;
        chk(unlock, exp);
    endtask : key

    task automatic t_protect;
        int i;
        for (i = 0; i < 5; i++) begin
            acc(prot[i], 1'b1, 1'b0, 2'h1);
            acc(prot[i], 1'b1, 1'b1, 2'h2);
        end
        acc(22'h00_0400, 1'b1, 1'b0, 2'h2);
        acc(22'h30_0000, 1'b0, 1'b0, 2'h0);
    endtask : t_protect

    task automatic t_key;
        int i;
        for (i = 0; i < 8; i++) acc(`SCEG_PW_BASE + 22'(i), 1'b1, 1'b0, 2'h1);
        key(~pw_lo, 1'b0);
        key(pw_lo, 1'b1);
        emu_att = 1'b1;
        repeat (3) @(negedge clk);
        acc(22'h30_0000, 1'b0, 1'b0, 2'h0);
        acc(22'h00_8000, 1'b1, 1'b0, 2'h1);
        chk(cut, 1'b0);
    endtask : t_key

    task automatic t_trip;
        do_reset;
        chk({hold, cut, unlock}, 64'h0);
        acc(22'h3F_8000, 1'b0, 1'b0, 2'h0);
        chk(cut, 1'b1);
        repeat (5) @(negedge clk);
        chk(cut, 1'b1);
    endtask : t_trip

    task automatic t_blank;
        pw_lo = 64'hFFFF_FFFF_FFFF_FFFF;
        slow = 2'h0;
        do_reset;
        repeat (2) @(negedge clk);
        chk(unlock, 1'b1);
        acc(22'h00_B000, 1'b0, 1'b0, 2'h0);
        chk(cut, 1'b0);
    endtask : t_blank

    task automatic t_wait;
        int i;
        pw_lo = 64'h0BAD_F00D_1234_0001;
        slow = 2'h1;
        emu_wrm = 1'b1;
        do_reset;
        chk(hold, 1'b1);
        acc(22'h30_0000, 1'b0, 1'b0, 2'h0);
        chk(cut, 1'b0);
        emu_ctl = 1'b1;
        for (i = 0; i < 20 && hold !== 1'b0; i++) @(negedge clk);
        chk({hold, cut}, 64'h0);
        acc(22'h00_8000, 1'b1, 1'b0, 2'h1);
        chk(cut, 1'b1);
    endtask : t_wait

    initial begin
        do_reset;
        chk(hold, 1'b0);
        t_protect;
        t_key;
        t_trip;
        t_blank;
        t_wait;
        chk(order_err, 1'b0);
        close_out;
    end

    // Whole run is a few hundred cycles; this leaves ample margin
    initial begin
        #50000;
        n_errors++;
        close_out;
    end
endmodule : tb_sceg_guard
`default_nettype wire
